// ===== adcc_regs.sv
// converter control, result and interrupt register block on apb
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module adcc_regs
    import adcc_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         clkEn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    input  wire logic [11:0]  sampleIn,
    input  wire logic         lvdInUse,
    output adcc_analog_s      analogCtl,
    output logic              convReset,
    output logic              convSample,
    output logic              irqOut
);
    logic [7:0]  control;
    logic [7:0]  adcConfig;
    logic [7:0]  pinEnable;
    logic [7:0]  resultLow;
    logic [7:0]  resultHigh;
    logic        irqStatus;
    logic        irqEnable;
    logic [11:0] sampleMeta;
    logic [11:0] sampleSync;
    logic [5:0]  divCount;
    logic [4:0]  convCount;
    logic        converting;
    logic        startPrev;

    logic        wrEn;
    logic        rdEn;
    logic        known;
    logic        convTick;
    logic        startFall;
    logic        convDone;
    logic [31:0] next_prdata;

    // decoder for implemented offsets
    function automatic logic mapped(input logic [11:0] a);
        return a == ADDR_RESULT_LOW || a == ADDR_RESULT_HIGH || a == ADDR_CONTROL
            || a == ADDR_CONFIG || a == ADDR_PIN_ENABLE || a == ADDR_IRQ_STATUS
            || a == ADDR_IRQ_CLEAR || a == ADDR_IRQ_ENABLE;
    endfunction

    // divisor terminal count for the clock select code
    function automatic logic [5:0] divLast(input logic [2:0] code);
        logic [2:0] c;
        c = (code == DIV_UNDEFINED) ? DIV_MAX : code;
        return 6'((7'h01 << c) - 7'h01);
    endfunction

    assign known     = mapped(paddr);
    // writes land at the edge where the master samples pready high
    assign wrEn      = psel && penable && pwrite && pready && known;
    assign rdEn      = psel && penable && !pwrite && !pready;
    assign startFall = startPrev && !control[CTL_START];
    assign convTick  = converting && divCount == divLast(adcConfig[2:0]);
    assign convDone  = convTick && convCount == CONV_CYCLES - 5'h01;

    // apb handshake, one wait state
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clkEn)
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !known;
        end
    end

    always_comb
    begin
        next_prdata = 32'h00000000;
        unique case (paddr)
            ADDR_RESULT_LOW:  next_prdata[7:0] = resultLow;
            ADDR_RESULT_HIGH: next_prdata[7:0] = resultHigh;
            ADDR_CONTROL:     next_prdata[7:0] = control;
            ADDR_CONFIG:      next_prdata[7:0] = adcConfig;
            ADDR_PIN_ENABLE:  next_prdata[7:0] = pinEnable;
            ADDR_IRQ_STATUS:  next_prdata[0]   = irqStatus;
            ADDR_IRQ_ENABLE:  next_prdata[0]   = irqEnable;
            default:          next_prdata      = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            prdata <= 32'h00000000;
        else if (clkEn && rdEn)
            prdata <= next_prdata;
    end

    // control register with hardware busy flag
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            control <= CONTROL_RESET;
        else if (clkEn)
        begin
            if (wrEn && paddr == ADDR_CONTROL)
                control <= (pwdata[7:0] & CONTROL_WMASK) | (control & ~CONTROL_WMASK);
            if (control[CTL_START] || startFall)
                control[CTL_BUSY] <= 1'b1;
            else if (convDone)
                control[CTL_BUSY] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            adcConfig <= CONFIG_RESET;
            pinEnable <= PIN_RESET;
            irqEnable <= 1'b0;
        end
        else if (clkEn && wrEn)
        begin
            if (paddr == ADDR_CONFIG)
                adcConfig <= pwdata[7:0] & CONFIG_WMASK;
            if (paddr == ADDR_PIN_ENABLE)
                pinEnable <= pwdata[7:0] & PIN_WMASK;
            if (paddr == ADDR_IRQ_ENABLE)
                irqEnable <= pwdata[0];
        end
    end

    // sample input synchroniser
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sampleMeta <= 12'h000;
            sampleSync <= 12'h000;
        end
        else if (clkEn)
        begin
            sampleMeta <= sampleIn;
            sampleSync <= sampleMeta;
        end
    end

    // conversion sequencer
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            startPrev  <= 1'b0;
            converting <= 1'b0;
            divCount   <= 6'h00;
            convCount  <= 5'h00;
        end
        else if (clkEn)
        begin
            startPrev <= control[CTL_START];
            if (control[CTL_START] || control[CTL_PWROFF])
            begin
                converting <= 1'b0;
                divCount   <= 6'h00;
                convCount  <= 5'h00;
            end
            else if (startFall)
            begin
                converting <= 1'b1;
                divCount   <= 6'h00;
                convCount  <= 5'h00;
            end
            else if (converting)
            begin
                divCount <= convTick ? 6'h00 : 6'(divCount + 6'h01);
                if (convTick)
                    convCount <= 5'(convCount + 5'h01);
                if (convDone)
                    converting <= 1'b0;
            end
        end
    end

    // result packing at conversion end
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            resultLow  <= 8'h00;
            resultHigh <= 8'h00;
        end
        else if (clkEn && convDone)
        begin
            if (control[CTL_FORMAT])
            begin
                resultHigh <= {4'h0, sampleSync[11:8]};
                resultLow  <= sampleSync[7:0];
            end
            else
            begin
                resultHigh <= sampleSync[11:4];
                resultLow  <= {sampleSync[3:0], 4'h0};
            end
        end
    end

    // interrupt flag, set wins over clear
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            irqStatus <= 1'b0;
        else if (clkEn)
        begin
            if (convDone)
                irqStatus <= 1'b1;
            else if (wrEn && paddr == ADDR_IRQ_CLEAR && pwdata[0])
                irqStatus <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            irqOut <= 1'b0;
        else if (clkEn)
            irqOut <= irqStatus && irqEnable;
    end

    // analog routing outputs
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            analogCtl  <= '{powerDown: 1'b1, bandgapOn: 1'b0, extRefSel: 1'b0,
                           routeValid: 1'b0, inputSel: SEL_IN0, analogPin: PIN_RESET[3:0]};
            convReset  <= 1'b1;
            convSample <= 1'b0;
        end
        else if (clkEn)
        begin
            analogCtl.powerDown <= control[CTL_PWROFF];
            analogCtl.bandgapOn <= adcConfig[CFG_BGEN] && (adcConfig[CFG_INTREF] || lvdInUse);
            analogCtl.extRefSel <= adcConfig[CFG_REFSEL];
            if (adcConfig[CFG_INTREF])
            begin
                analogCtl.inputSel   <= SEL_BANDGAP;
                analogCtl.routeValid <= 1'b1;
            end
            else
            begin
                analogCtl.inputSel   <= adcc_sel_e'(control[1:0]);
                analogCtl.routeValid <= control[1:0] != CHAN_UNUSABLE;
            end
            analogCtl.analogPin <= pinEnable[3:0];
            convReset  <= control[CTL_START] || control[CTL_PWROFF];
            convSample <= convDone;
        end
    end
endmodule

// ===== adcc_pkg.sv
// package for the converter control register block
package adcc_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_RESULT_LOW  = 12'h000;
    localparam logic [11:0] ADDR_RESULT_HIGH = 12'h004;
    localparam logic [11:0] ADDR_CONTROL     = 12'h008;
    localparam logic [11:0] ADDR_CONFIG      = 12'h00c;
    localparam logic [11:0] ADDR_PIN_ENABLE  = 12'h010;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h014;
    localparam logic [11:0] ADDR_IRQ_CLEAR   = 12'h018;
    localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'h01c;

    // control field positions
    localparam int CTL_START   = 7;
    localparam int CTL_BUSY    = 6;
    localparam int CTL_PWROFF  = 5;
    localparam int CTL_FORMAT  = 4;
    // config field positions
    localparam int CFG_INTREF  = 7;
    localparam int CFG_BGEN    = 6;
    localparam int CFG_REFSEL  = 4;

    // writable masks, unimplemented bits read zero
    localparam logic [7:0] CONTROL_WMASK = 8'hb3;
    localparam logic [7:0] CONFIG_WMASK  = 8'hd7;
    localparam logic [7:0] PIN_WMASK     = 8'h0f;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h60;
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam logic [7:0] PIN_RESET     = 8'h0f;

    localparam logic [1:0] CHAN_UNUSABLE = 2'h3;
    localparam logic [2:0] DIV_UNDEFINED = 3'h7;
    localparam logic [2:0] DIV_MAX       = 3'h6;

    // converter clock cycles per conversion
    localparam logic [4:0] CONV_CYCLES   = 5'h10;

    typedef enum logic [1:0] { SEL_IN0, SEL_IN1, SEL_IN2, SEL_BANDGAP } adcc_sel_e;

    typedef struct packed {
        logic      powerDown;
        logic      bandgapOn;
        logic      extRefSel;
        logic      routeValid;
        adcc_sel_e inputSel;
        logic [3:0] analogPin;
    } adcc_analog_s;
endpackage

// ===== adcc_analog_model.sv
// analog source model feeding the converter core result
`timescale 1ns/1ps
module adcc_analog_model
    import adcc_pkg::*;
#(
    parameter logic [47:0] LEVELS = 48'h8015e73c9a53
)
(
    input  wire logic         sys_clk,
    input  wire adcc_analog_s analogCtl,
    output logic [11:0]       sampleIn
);
    logic [11:0] junk = 12'h000;
    logic        live;
    // junk changes every cycle so a dead source never looks valid
    always_ff @(posedge sys_clk)
        junk <= junk + 12'h5a5;
    // level only while powered and the bandgap is on when picked
    assign live = analogCtl.routeValid && !analogCtl.powerDown
                  && (analogCtl.inputSel != SEL_BANDGAP || analogCtl.bandgapOn);
    assign sampleIn = live ? LEVELS[12*int'(analogCtl.inputSel) +: 12] : junk;
endmodule

// ===== adcc_regs_properties.sv
// port checker for the converter register block
`timescale 1ns/1ps
module adcc_regs_properties
    import adcc_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         rst_b,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic         pready,
    input wire logic         lvdInUse,
    input wire logic [31:0]  prdata,
    input wire adcc_analog_s analogCtl,
    input wire logic         convReset,
    input wire logic         convSample,
    input wire logic         irqOut
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic [11:0] wa;
    // address of a write at its taking edge, else an unmapped one
    assign wa = (psel && penable && pwrite && pready) ? paddr : 12'hfff;
    property p_start;
        wa == ADDR_CONTROL && pwdata[CTL_START] |-> ##2 convReset;
    endproperty
    a_start: assert property (p_start) else $error("start not holding reset");
    property p_off;
        wa == ADDR_CONTROL |-> ##2 analogCtl.powerDown == $past(pwdata[CTL_PWROFF], 2);
    endproperty
    a_off: assert property (p_off) else $error("power state wrong");
    property p_bg;
        wa == ADDR_CONFIG && pwdata[CFG_INTREF] |-> ##2 analogCtl.inputSel == SEL_BANDGAP;
    endproperty
    a_bg: assert property (p_bg) else $error("bandgap not routed");
    property p_bgon;
        wa == ADDR_CONFIG |-> ##2 analogCtl.bandgapOn == ($past(pwdata[CFG_BGEN], 2)
            && ($past(pwdata[CFG_INTREF], 2) || $past(lvdInUse)));
    endproperty
    a_bgon: assert property (p_bgon) else $error("bandgap power wrong");
    property p_ref;
        wa == ADDR_CONFIG |-> ##2 analogCtl.extRefSel == $past(pwdata[CFG_REFSEL], 2);
    endproperty
    a_ref: assert property (p_ref) else $error("reference select wrong");
    property p_pin;
        wa == ADDR_PIN_ENABLE |-> ##2 analogCtl.analogPin == $past(pwdata[3:0], 2);
    endproperty
    a_pin: assert property (p_pin) else $error("pin mode wrong");
    property p_pulse;
        convSample |=> !convSample;
    endproperty
    a_pulse: assert property (p_pulse) else $error("sample pulse too long");
    property p_clr;
        wa == ADDR_IRQ_CLEAR && pwdata[0] ##1 !convSample [*3] |-> !irqOut;
    endproperty
    a_clr: assert property (p_clr) else $error("interrupt not cleared");
    property p_zero;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("unused read bits set");
    c_conv: cover property (convSample);
    c_irq: cover property (irqOut);
    c_bg: cover property (convSample && analogCtl.inputSel == SEL_BANDGAP);
endmodule
bind adcc_regs adcc_regs_properties chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .lvdInUse(lvdInUse),
    .prdata(prdata), .analogCtl(analogCtl), .convReset(convReset),
    .convSample(convSample), .irqOut(irqOut));

// ===== adcc_regs_bench.sv
// self-checking bench for the converter register block
`timescale 1ns/1ps
module adcc_regs_bench
    import adcc_pkg::*;
;
    localparam int SETTLE = 40;
    logic         sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic         convReset, convSample, irqOut, lvdInUse;
    logic [11:0]  paddr, sampleIn;
    logic [31:0]  pwdata, prdata, rdv;
    adcc_analog_s analogCtl;
    int           miscompares = 0;
    int           compares = 0;
    // control, config, result high, result low
    logic [31:0]  rows [7] = '{32'h0000a530, 32'h110103c9, 32'h02025e70, 32'h10c30801,
                               32'h10040a53, 32'h01053c90, 32'h00d68010};
    adcc_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sampleIn(sampleIn), .lvdInUse(lvdInUse),
        .analogCtl(analogCtl), .convReset(convReset), .convSample(convSample), .irqOut(irqOut));
    adcc_analog_model src (.sys_clk(sys_clk), .analogCtl(analogCtl), .sampleIn(sampleIn));
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic expire();
        miscompares++;
        results();
    endtask
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            expire();
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, rdv, e);
    endtask
    task automatic convert(input logic [7:0] ctl, input logic [2:0] dv);
        int n;
        apb(1'b1, ADDR_CONTROL, {24'h0, ctl | 8'h80});
        rd(ADDR_CONTROL, {24'h0, ctl | 8'hc0}, "busyHeld");
        apb(1'b1, ADDR_CONTROL, {24'h0, ctl});
        n = 0;
        while (convSample !== 1'b1 && n < 3000)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (convSample !== 1'b1)
            expire();
        check("convTime", 32'(n >= (16 << dv) - 4 && n <= (18 << dv) + 8), 32'h1);
        rd(ADDR_CONTROL, {24'h0, ctl}, "busyDone");
    endtask
    initial
    begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lvdInUse = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 7; i++)
        begin
            // bandgap enable set first, then picked, which powers it, and left to settle
            if (rows[i][23])
                apb(1'b1, ADDR_CONFIG, 32'h40);
            apb(1'b1, ADDR_CONFIG, {24'h0, rows[i][23:16]});
            if (rows[i][23])
                repeat (SETTLE) @(posedge sys_clk);
            convert(rows[i][31:24], rows[i][18:16]);
            rd(ADDR_RESULT_HIGH, {24'h0, rows[i][15:8]}, "resultHigh");
            rd(ADDR_RESULT_LOW, {24'h0, rows[i][7:0]}, "resultLow");
        end
        rd(ADDR_IRQ_STATUS, 32'h1, "irqStatus");
        check("irqMasked", 32'(irqOut), 32'h0);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
        @(posedge sys_clk);
        check("irqRaised", 32'(irqOut), 32'h1);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
        @(posedge sys_clk);
        check("irqCleared", 32'(irqOut), 32'h0);
        rd(ADDR_IRQ_STATUS, 32'h0, "irqStatusClr");
        apb(1'b1, ADDR_CONFIG, 32'h0);
        convert(8'h02, 3'h0);
        check("irqAgain", 32'(irqOut), 32'h1);
        // bandgap kept on for low-voltage use, then switched off when unused
        lvdInUse <= 1'b1;
        apb(1'b1, ADDR_CONFIG, 32'h40);
        @(posedge sys_clk);
        check("bgLvd", 32'(analogCtl.bandgapOn), 32'h1);
        lvdInUse <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("bgAutoOff", 32'(analogCtl.bandgapOn), 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h03);
        @(posedge sys_clk);
        check("chanUnusable", 32'(analogCtl.routeValid), 32'h0);
        apb(1'b1, ADDR_RESULT_LOW, 32'hff);
        rd(ADDR_RESULT_LOW, 32'h70, "resultRO");
        rd(12'h020, 32'h0, "unmapped");
        check("slvErr", 32'(err), 32'h1);
        apb(1'b1, ADDR_CONFIG, 32'hff);
        rd(ADDR_CONFIG, 32'hd7, "cfgMask");
        // undefined divider code runs at the slowest divisor
        convert(8'h00, 3'h6);
        apb(1'b1, ADDR_PIN_ENABLE, 32'hfa);
        rd(ADDR_PIN_ENABLE, 32'h0a, "pinMask");
        apb(1'b1, ADDR_CONTROL, 32'ha0);
        apb(1'b1, ADDR_CONTROL, 32'h20);
        rd(ADDR_CONTROL, 32'h60, "offNoConv");
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(ADDR_CONTROL, 32'h60, "ctlReset");
        rd(ADDR_CONFIG, 32'h00, "cfgReset");
        rd(ADDR_PIN_ENABLE, 32'h0f, "pinReset");
        results();
    end
endmodule
